// file: rtl/pxscan_pkg.sv
package pxscan_pkg;
  localparam int NUM_SENSORS = 4;
  localparam int CLK_FREQ_HZ = 100000000;
  localparam int CLK_PERIOD_NS = 10;
  // Delay from gate rise to first measurement, in microseconds.
  localparam int GATE_START_DELAY_US = 100;
  localparam int GATE_START_DELAY_CYC = GATE_START_DELAY_US * (CLK_FREQ_HZ / 1000000);
  // Scan periods and the active hold time, in milliseconds.
  localparam int ACTIVE_PERIOD_MS = 30;
  localparam int DOZE_PERIOD_MS = 240;
  localparam int ACTIVE_HOLD_MS = 240;
  localparam int CYC_PER_MS = CLK_FREQ_HZ / 1000;
  localparam int ACTIVE_PERIOD_CYC = ACTIVE_PERIOD_MS * CYC_PER_MS;
  localparam int DOZE_PERIOD_CYC = DOZE_PERIOD_MS * CYC_PER_MS;
  localparam int ACTIVE_HOLD_CYC = ACTIVE_HOLD_MS * CYC_PER_MS;
  // Least host reset pulse, in nanoseconds, and as clock cycles.
  localparam int RESET_PULSE_MIN_NS = 20;
  localparam int RESET_PULSE_MIN_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 32;
  typedef enum logic [5:0] {
    PXS_SLEEP = 6'h01,
    PXS_START = 6'h02,
    PXS_MEAS = 6'h04,
    PXS_PROC = 6'h08,
    PXS_IDLE = 6'h10,
    PXS_COMP = 6'h20
  } pxs_state_t;
endpackage : pxscan_pkg

// file: rtl/pxscan_seq.sv
`timescale 1ns/1ps
module pxscan_seq
  import pxscan_pkg::*;
#(
  parameter int START_DELAY_CYC = GATE_START_DELAY_CYC,
  parameter int ACT_PERIOD_CYC = ACTIVE_PERIOD_CYC,
  parameter int DZ_PERIOD_CYC = DOZE_PERIOD_CYC,
  parameter int HOLD_CYC = ACTIVE_HOLD_CYC
) (
  // Clock and reset.
  input wire logic REF_CLK_IN,
  input wire logic RESET_N_IN,
  // Host pins.
  input wire logic TRANSMIT_GATE_IN,
  // Front end: one comparison result per sensor, valid when a measure completes.
  input wire logic [NUM_SENSORS-1:0] SENSOR_INPUT_IN,
  input wire logic MEAS_DONE_IN,
  input wire logic COMP_REQ_IN,
  input wire logic COMP_DONE_IN,
  // Front end control.
  output logic FRONT_END_ON_OUT,
  output logic MEAS_START_OUT,
  output logic [1:0] MEAS_SEL_OUT,
  output logic GUARD_DRIVE_OUT,
  // Status.
  output logic [NUM_SENSORS-1:0] PROX_N_OUT,
  output logic ACTIVE_MODE_OUT,
  output logic SLEEP_MODE_OUT
);
  logic gate_s1, gate_s2, gate_d;
  logic [NUM_SENSORS-1:0] sens_s1, sens_s2;
  logic done_s1, done_s2, creq_s1, creq_s2, cdone_s1, cdone_s2;
  pxs_state_t state, next_state;
  logic [CNT_W-1:0] timer, next_timer, hold, next_hold;
  logic [1:0] sel, next_sel;
  logic [NUM_SENSORS-1:0] sample, next_sample, prox, next_prox;
  logic active, next_active, armed, next_armed, comp_pend, next_comp_pend;
  logic start_pulse, next_start_pulse;

  // Every outside input except clock and reset passes two flip-flops first.
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      gate_s1 <= 1'b0;
      gate_s2 <= 1'b0;
      gate_d <= 1'b0;
      sens_s1 <= '0;
      sens_s2 <= '0;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      creq_s1 <= 1'b0;
      creq_s2 <= 1'b0;
      cdone_s1 <= 1'b0;
      cdone_s2 <= 1'b0;
    end else begin
      gate_s1 <= TRANSMIT_GATE_IN;
      gate_s2 <= gate_s1;
      gate_d <= gate_s2;
      sens_s1 <= SENSOR_INPUT_IN;
      sens_s2 <= sens_s1;
      done_s1 <= MEAS_DONE_IN;
      done_s2 <= done_s1;
      creq_s1 <= COMP_REQ_IN;
      creq_s2 <= creq_s1;
      cdone_s1 <= COMP_DONE_IN;
      cdone_s2 <= cdone_s1;
    end
  end

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_hold = hold;
    next_sel = sel;
    next_sample = sample;
    next_prox = prox;
    next_active = active;
    next_start_pulse = 1'b0;
    next_comp_pend = comp_pend | creq_s2;
    // A rising gate arms a run; a low gate disarms at once, and the run ends after the current sequence.
    next_armed = gate_s2 ? (armed | ~gate_d) : 1'b0;
    case (state)
      PXS_SLEEP: begin
        if (gate_s2 && !gate_d) begin
          next_state = PXS_START;
          next_timer = CNT_W'(START_DELAY_CYC - 1);
        end
      end
      PXS_START: begin
        if (!gate_s2) begin
          next_state = PXS_SLEEP;
        end else if (timer == '0) begin
          next_state = PXS_MEAS;
          next_sel = 2'h0;
          next_start_pulse = 1'b1;
        end else begin
          next_timer = timer - 1'b1;
        end
      end
      PXS_MEAS: begin
        if (done_s2) begin
          next_sample[sel] = sens_s2[sel];
          if (sel == 2'(NUM_SENSORS - 1)) begin
            next_state = PXS_PROC;
          end else begin
            next_sel = sel + 2'h1;
            next_start_pulse = 1'b1;
          end
        end
      end
      PXS_PROC: begin
        next_prox = comp_pend ? '0 : sample;
        if (sample != '0) begin
          next_active = 1'b1;
          next_hold = CNT_W'(HOLD_CYC - 1);
        end else if (hold >= CNT_W'(ACT_PERIOD_CYC)) begin
          next_hold = hold - CNT_W'(ACT_PERIOD_CYC);
        end else begin
          next_active = 1'b0;
          next_hold = '0;
        end
        next_timer = CNT_W'((next_active ? ACT_PERIOD_CYC : DZ_PERIOD_CYC) - 1);
        if (comp_pend) begin
          next_state = PXS_COMP;
        end else if (!armed) begin
          next_state = PXS_SLEEP;
        end else begin
          next_state = PXS_IDLE;
        end
      end
      PXS_IDLE: begin
        if (!armed) begin
          next_state = PXS_SLEEP;
        end else if (timer == '0) begin
          next_state = PXS_MEAS;
          next_sel = 2'h0;
          next_start_pulse = 1'b1;
        end else begin
          next_timer = timer - 1'b1;
        end
      end
      PXS_COMP: begin
        next_prox = '0;
        next_comp_pend = creq_s2;
        if (cdone_s2) begin
          next_state = armed ? PXS_IDLE : PXS_SLEEP;
        end
      end
      default: next_state = PXS_SLEEP;
    endcase
    if (!gate_s2 && state == PXS_SLEEP) begin
      next_active = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state <= PXS_SLEEP;
      timer <= '0;
      hold <= '0;
      sel <= 2'h0;
      sample <= '0;
      prox <= '0;
      active <= 1'b0;
      armed <= 1'b0;
      comp_pend <= 1'b1;
      start_pulse <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      hold <= next_hold;
      sel <= next_sel;
      sample <= next_sample;
      prox <= next_prox;
      active <= next_active;
      armed <= next_armed;
      comp_pend <= next_comp_pend;
      start_pulse <= next_start_pulse;
    end
  end

  assign FRONT_END_ON_OUT = (state == PXS_MEAS) || (state == PXS_COMP);
  assign MEAS_START_OUT = start_pulse;
  assign MEAS_SEL_OUT = sel;
  assign GUARD_DRIVE_OUT = (state == PXS_MEAS);
  assign PROX_N_OUT = ~prox;
  assign ACTIVE_MODE_OUT = active & gate_s2;
  assign SLEEP_MODE_OUT = (state == PXS_SLEEP);

  a_start_delay: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (state == PXS_SLEEP && next_state == PXS_START) |=> (state == PXS_START) [*8])
    else $error("Measurement began before the start delay.");
  a_seq_order: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (state == PXS_MEAS && done_s2 && sel != 2'h3) |=> (sel == $past(sel) + 2'h1))
    else $error("Sensors not visited in ascending order.");
  a_proc_after: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (state == PXS_PROC) |-> ($past(state) == PXS_MEAS && $past(sel) == 2'h3))
    else $error("Processing began before all sensors were measured.");
  a_guard: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (state == PXS_MEAS) |-> GUARD_DRIVE_OUT && FRONT_END_ON_OUT)
    else $error("Guard not driven during measurement.");
  a_idle_off: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (state == PXS_IDLE) |-> !FRONT_END_ON_OUT)
    else $error("Front end powered during idle.");
  a_period_load: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (state == PXS_PROC) |=> (timer == CNT_W'(active ? ACT_PERIOD_CYC - 1 : DZ_PERIOD_CYC - 1)))
    else $error("Scan period timer loaded with the wrong count.");
  a_active_on: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (state == PXS_PROC && sample != '0) |=> active)
    else $error("Active mode not entered on proximity.");
  a_comp_clear: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (state == PXS_COMP || (state == PXS_PROC && comp_pend)) |=> (PROX_N_OUT == '1))
    else $error("Flags active during compensation.");
  a_flag_stable: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (state != PXS_PROC && state != PXS_COMP) |=> $stable(PROX_N_OUT))
    else $error("Flag changed outside a scan update.");
  a_gate_stop: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
    (state == PXS_IDLE && !armed) |=> (state == PXS_SLEEP))
    else $error("Scanning continued after gate fell.");
endmodule : pxscan_seq

// file: verif/pxscan_fe_model.sv
`timescale 1ns/1ps
module pxscan_fe_model (
  input wire logic clk_in,
  input wire logic meas_start_in,
  input wire logic guard_in,
  input wire logic front_end_on_in,
  input wire logic [3:0] near_mask_in,
  input wire logic [3:0] lat_in,
  output logic done_out,
  output logic [3:0] sense_out,
  output logic comp_done_out
);
  initial begin
    done_out = 1'b0;
    comp_done_out = 1'b0;
  end
  // Results are valid only while sensing; otherwise the lines flip.
  assign sense_out = guard_in ? near_mask_in : ~near_mask_in;
  // Each started measurement ends with a one-cycle done pulse after lat_in cycles.
  always @(posedge clk_in) begin
    if (meas_start_in) begin
      repeat (lat_in) @(negedge clk_in);
      done_out = 1'b1;
      @(negedge clk_in);
      done_out = 1'b0;
    end
  end
  always @(negedge clk_in) comp_done_out <= front_end_on_in & ~guard_in;
endmodule : pxscan_fe_model

// file: verif/test_proximity_scan_sequencer.sv
`timescale 1ns/1ps
module test_proximity_scan_sequencer;
  import pxscan_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic gate = 1'b0;
  logic comp_req = 1'b0;
  logic [3:0] near = 4'h5;
  logic [3:0] lat = 4'h1;
  logic [3:0] sense;
  logic [3:0] prox_n;
  logic [1:0] sel;
  logic done, comp_done, fe_on, mstart, guard, act, slp;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int starts[$];
  logic [1:0] sels[$];
  always #5 clk = ~clk;
  pxscan_seq #(.START_DELAY_CYC(10), .ACT_PERIOD_CYC(20), .DZ_PERIOD_CYC(160), .HOLD_CYC(160)) u_dut (
    .REF_CLK_IN(clk), .RESET_N_IN(rst_n), .TRANSMIT_GATE_IN(gate), .SENSOR_INPUT_IN(sense),
    .MEAS_DONE_IN(done), .COMP_REQ_IN(comp_req), .COMP_DONE_IN(comp_done), .FRONT_END_ON_OUT(fe_on),
    .MEAS_START_OUT(mstart), .MEAS_SEL_OUT(sel), .GUARD_DRIVE_OUT(guard), .PROX_N_OUT(prox_n),
    .ACTIVE_MODE_OUT(act), .SLEEP_MODE_OUT(slp));
  pxscan_fe_model u_fe (.clk_in(clk), .meas_start_in(mstart), .guard_in(guard), .front_end_on_in(fe_on),
    .near_mask_in(near), .lat_in(lat), .done_out(done), .sense_out(sense), .comp_done_out(comp_done));
  task check(input logic [3:0] got, input logic [3:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mstart === 1'b1) begin
      sels.push_back(sel);
      if (sel === 2'h0) starts.push_back(cyc);
      check({3'h0, guard}, 4'h1, "guard while measuring");
    end
  end
  task wait_scans(input int n);
    for (int k = 0; k < 3000 && starts.size() < n; k++) @(negedge clk);
    if (starts.size() < n) check(4'h0, 4'h1, "scan wait timed out");
  endtask : wait_scans
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task test_reset;
    check(prox_n, 4'hf, "flags after reset");
    check({3'h0, slp}, 4'h1, "sleep with gate low");
    $display("test reset done");
  endtask : test_reset
  task test_start;
    int t0;
    t0 = cyc;
    gate = 1'b1;
    wait_scans(1);
    check({3'h0, starts[0] - t0 >= 10}, 4'h1, "start delay");
    for (int k = 0; k < 300 && !(fe_on === 1'b1 && guard === 1'b0); k++) @(negedge clk);
    for (int i = 0; i < 4; i++) check({2'h0, sels[i]}, i[3:0], "sensor order");
    check(prox_n, 4'hf, "flags during compensation");
    $display("test start done");
  endtask : test_start
  task test_active;
    lat = 4'h6;
    wait_scans(4);
    check(prox_n, 4'ha, "near flags");
    check({2'h0, act, slp}, 4'h2, "active mode");
    check({3'h0, starts[3] - starts[2] >= 20 && starts[3] - starts[2] < 160}, 4'h1, "active gap");
    $display("test active done");
  endtask : test_active
  task test_drift;
    comp_req = 1'b1;
    repeat (4) @(negedge clk);
    comp_req = 1'b0;
    for (int k = 0; k < 300 && !(fe_on === 1'b1 && guard === 1'b0); k++) @(negedge clk);
    check(prox_n, 4'hf, "flags during drift compensation");
    check({3'h0, act}, 4'h1, "active kept through compensation");
    wait_scans(starts.size() + 2);
    check(prox_n, 4'ha, "flags back after compensation");
    $display("test drift done");
  endtask : test_drift
  task test_doze;
    int n;
    near = 4'h0;
    n = starts.size();
    wait_scans(n + 2);
    check(prox_n, 4'hf, "far flags");
    wait_scans(n + 12);
    check({3'h0, act}, 4'h0, "back to doze");
    n = starts.size();
    wait_scans(n + 2);
    check({3'h0, starts[n + 1] - starts[n] >= 160}, 4'h1, "doze gap");
    $display("test doze done");
  endtask : test_doze
  task test_gate_fall;
    int n, s;
    s = starts.size();
    wait_scans(s + 1);
    n = sels.size() - 1;
    gate = 1'b0;
    repeat (400) @(negedge clk);
    check(4'(sels.size() - n), 4'h4, "scan finished after gate fall");
    check(4'(starts.size() - s), 4'h1, "no scan after gate fall");
    check({3'h0, slp}, 4'h1, "sleep after gate fall");
    s = starts.size();
    gate = 1'b1;
    repeat (8) @(negedge clk);
    gate = 1'b0;
    repeat (40) @(negedge clk);
    check(4'(starts.size() - s), 4'h0, "no scan when gate falls in start delay");
    check({3'h0, slp}, 4'h1, "sleep after short gate");
    $display("test gate fall done");
  endtask : test_gate_fall
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    test_reset();
    test_start();
    test_active();
    test_drift();
    test_doze();
    test_gate_fall();
    summarize();
  end
  initial begin
    repeat (8000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule : test_proximity_scan_sequencer
